/* rtl/mrs_pkg.sv */
`default_nettype none
package mrs_pkg;
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned MCD_TIME_NS   = 100000;
	localparam int unsigned MCD_CYC       = (MCD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WDT_DIV       = 12;
	localparam int unsigned RST_HOLD_CYC  = 16;
	// User code limits
	localparam logic [15:0] LIMIT_8K      = 16'h1FFF;
	localparam logic [15:0] LIMIT_16K     = 16'h3DFF;
	// Register byte addresses
	localparam logic [7:0]  ADDR_RST_SRC  = 8'h00;
	localparam logic [7:0]  ADDR_CAUSE    = 8'h04;
	localparam logic [7:0]  ADDR_WDT_CTRL = 8'h08;
	localparam logic [7:0]  ADDR_WDT_LIM  = 8'h0C;
	localparam logic [7:0]  ADDR_WDT_KICK = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h18;
	localparam logic [7:0]  ADDR_IRQ_EN   = 8'h1C;
	// Register bit positions: reset source register, and BIT_WDT_EN in the watchdog control register
	localparam int unsigned BIT_MCD       = 2;
	localparam int unsigned BIT_SW        = 4;
	localparam int unsigned BIT_CMP       = 5;
	localparam int unsigned BIT_MEM       = 6;
	localparam int unsigned BIT_WDT_EN    = 0;
	// Event index, lowest index wins
	localparam int unsigned EV_MEM        = 0;
	localparam int unsigned EV_WDT        = 1;
	localparam int unsigned EV_CMP        = 2;
	localparam int unsigned EV_MCD        = 3;
	localparam int unsigned EV_SW         = 4;
	localparam int unsigned NUM_EV        = 5;
	// Watchdog limit reset value and bus response codes
	localparam logic [15:0] WDT_LIM_RST   = 16'hFFFF;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_DECERR   = 2'h3;
	typedef enum {ST_RUN, ST_HOLD} mrs_state_t;
endpackage
`default_nettype wire

/* rtl/mrs_wdt_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface mrs_wdt_if;
	logic        enable;
	logic        kick;
	logic        hold;
	logic [15:0] limit;
	logic        timeout;
	modport ctl (output enable, output kick, output hold, output limit, input timeout);
	modport dog (input enable, input kick, input hold, input limit, output timeout);
endinterface
`default_nettype wire

/* rtl/mrs_watchdog.sv */
`timescale 1ns/100ps
`default_nettype none
module mrs_watchdog
	import mrs_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	mrs_wdt_if.dog    wd
);
	localparam logic [3:0] DIV_LAST = 4'(WDT_DIV - 1);
	logic [3:0]  div_q;
	logic [15:0] cnt_q;
	logic        tick;
	logic        to_q;

	assign tick = (div_q == DIV_LAST);
	assign wd.timeout = to_q;

	// Prescaler, one enable pulse per twelve clocks
	always_ff @(posedge clk) begin
		if (!rst_n || wd.hold)
			div_q <= 4'h0;
		else if (tick)
			div_q <= 4'h0;
		else
			div_q <= div_q + 4'h1;
	end

	// Kick or disable restarts the count
	always_ff @(posedge clk) begin
		if (!rst_n || wd.hold || wd.kick || !wd.enable)
			cnt_q <= 16'h0000;
		else if (tick && cnt_q != wd.limit)
			cnt_q <= cnt_q + 16'h0001;
	end

	always_ff @(posedge clk) begin
		if (!rst_n || wd.hold)
			to_q <= 1'b0;
		else
			to_q <= wd.enable && !wd.kick && tick && cnt_q == wd.limit;
	end
endmodule // mrs_watchdog
`default_nettype wire

/* rtl/mrs_mem_guard.sv */
`timescale 1ns/100ps
`default_nettype none
module mrs_mem_guard
	import mrs_pkg::*;
#(
	parameter logic [15:0] USER_LIMIT = LIMIT_8K
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        prog_write_en,
	input  wire logic        dmove_wr,
	input  wire logic [15:0] dmove_addr,
	input  wire logic        table_rd,
	input  wire logic [15:0] table_addr,
	input  wire logic        branch_fetch,
	input  wire logic [15:0] fetch_addr,
	input  wire logic        security_block,
	output var  logic        err
);
	initial begin
		if (USER_LIMIT != LIMIT_8K && USER_LIMIT != LIMIT_16K)
			$error("USER_LIMIT must be one of the two code sizes");
	end

	function automatic logic above(input logic [15:0] a);
		return a > USER_LIMIT;
	endfunction

	always_ff @(posedge clk) begin
		if (!rst_n)
			err <= 1'b0;
		else
			err <= (prog_write_en && dmove_wr && above(dmove_addr))
				|| (table_rd && above(table_addr))
				|| (branch_fetch && above(fetch_addr))
				|| security_block;
	end
endmodule // mrs_mem_guard
`default_nettype wire

/* rtl/mrs_reset_top.sv */
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module mrs_reset_top
	import mrs_pkg::*;
#(
	parameter logic [15:0] USER_LIMIT = mrs_pkg::LIMIT_8K,
	parameter int unsigned HOLD_CYC   = mrs_pkg::RST_HOLD_CYC
) (
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	// AXI4-Lite slave
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output var  logic        S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output var  logic        S_AXI_WREADY,
	output var  logic [1:0]  S_AXI_BRESP,
	output var  logic        S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output var  logic        S_AXI_ARREADY,
	output var  logic [31:0] S_AXI_RDATA,
	output var  logic [1:0]  S_AXI_RRESP,
	output var  logic        S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// Sources
	input  wire logic        CLK_SENSE,
	input  wire logic        CMP_ABOVE,
	input  wire logic        PROG_WRITE_EN,
	input  wire logic        DMOVE_WR,
	input  wire logic [15:0] DMOVE_ADDR,
	input  wire logic        TABLE_RD,
	input  wire logic [15:0] TABLE_ADDR,
	input  wire logic        BRANCH_FETCH,
	input  wire logic [15:0] FETCH_ADDR,
	input  wire logic        SECURITY_BLOCK,
	// Results
	output var  logic        SYS_RST_N,
	output var  logic        IRQ
);
	import mrs_pkg::*;

	initial begin
		if (HOLD_CYC < 4 || HOLD_CYC > 255)
			$error("HOLD_CYC must lie in 4..255");
	end

	localparam logic [11:0] MCD_LIM  = 12'(MCD_CYC);
	localparam logic [7:0]  HOLD_END = 8'(HOLD_CYC - 1);

	mrs_wdt_if wd ();

	mrs_state_t          state_q;
	logic [7:0]          hold_q;
	logic                mcd_en_q;
	logic                cmp_en_q;
	logic                wdt_en_q;
	logic [15:0]         wdt_lim_q;
	logic                kick_q;
	logic                sw_req_q;
	logic [NUM_EV-1:0]   cause_q;
	logic [NUM_EV-1:0]   irq_st_q;
	logic [NUM_EV-1:0]   irq_en_q;
	logic                sense_q;
	logic [11:0]         mcd_cnt_q;
	logic                mcd_trip;
	logic                cmp_trip;
	logic                mem_err;
	logic [NUM_EV-1:0]   req;
	logic [NUM_EV-1:0]   pick;
	logic                fire;
	logic                rst_active;
	// Bus side
	logic                aw_have_q;
	logic [7:0]          aw_addr_q;
	logic                w_have_q;
	logic [31:0]         w_data_q;
	logic [3:0]          w_strb_q;
	logic                do_wr;
	logic [31:0]         rd_word;
	logic [NUM_EV-1:0]   irq_clr;
	logic [31:0]         lim_word;

	function automatic logic mapped(input logic [7:0] a);
		case (a)
			ADDR_RST_SRC, ADDR_CAUSE, ADDR_WDT_CTRL, ADDR_WDT_LIM,
			ADDR_WDT_KICK, ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	mrs_mem_guard #(
		.USER_LIMIT (USER_LIMIT)
	) u_guard (
		.clk            (MCLK),
		.rst_n          (RST_N),
		.prog_write_en  (PROG_WRITE_EN),
		.dmove_wr       (DMOVE_WR),
		.dmove_addr     (DMOVE_ADDR),
		.table_rd       (TABLE_RD),
		.table_addr     (TABLE_ADDR),
		.branch_fetch   (BRANCH_FETCH),
		.fetch_addr     (FETCH_ADDR),
		.security_block (SECURITY_BLOCK),
		.err            (mem_err)
	);

	mrs_watchdog u_wdt (
		.clk   (MCLK),
		.rst_n (RST_N),
		.wd    (wd.dog)
	);

	assign wd.enable = wdt_en_q;
	assign wd.kick   = kick_q;
	assign wd.hold   = rst_active;
	assign wd.limit  = wdt_lim_q;
	// Limit honours byte strobes; upper half of the word is not stored
	assign lim_word  = merge({16'h0000, wdt_lim_q}, w_data_q, w_strb_q);

	// Sources gathered; only one is taken per reset
	assign cmp_trip = cmp_en_q && !CMP_ABOVE;
	assign mcd_trip = mcd_en_q && mcd_cnt_q == MCD_LIM;
	always_comb begin
		req         = '0;
		req[EV_MEM] = mem_err;
		req[EV_WDT] = wd.timeout;
		req[EV_CMP] = cmp_trip;
		req[EV_MCD] = mcd_trip;
		req[EV_SW]  = sw_req_q;
	end
	assign pick       = req & (~req + NUM_EV'(1));
	assign fire       = state_q == ST_RUN && req != '0;
	assign rst_active = state_q == ST_HOLD;
	// Reset output SYS_RST_N is driven low for the whole ST_HOLD state
	assign SYS_RST_N  = !rst_active;
	assign IRQ        = |(irq_st_q & irq_en_q);

	// Missing-clock one-shot; sense is the sampled clock level
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			sense_q   <= 1'b0;
			mcd_cnt_q <= 12'h000;
		end else begin
			sense_q <= CLK_SENSE;
			if (CLK_SENSE != sense_q || !mcd_en_q || rst_active)
				mcd_cnt_q <= 12'h000;
			else if (mcd_cnt_q != MCD_LIM)
				mcd_cnt_q <= mcd_cnt_q + 12'h001;
		end
	end

	// Reset sequencer; release only when hold done and comparator clear
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			state_q <= ST_RUN;
			hold_q  <= 8'h00;
		end else begin
			case (state_q)
				ST_RUN: begin
					hold_q <= 8'h00;
					if (fire)
						state_q <= ST_HOLD;
				end
				ST_HOLD: begin
					if (hold_q != HOLD_END)
						hold_q <= hold_q + 8'h01;
					else if (!cmp_trip)
						state_q <= ST_RUN;
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	// Cause latched once, at assertion; survives the system reset
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			cause_q <= '0;
		else if (fire)
			cause_q <= pick;
	end

	// Interrupt status; a new event beats a clear in the same cycle
	assign irq_clr = (do_wr && aw_addr_q == ADDR_IRQ_CLR && w_strb_q[0])
		? w_data_q[NUM_EV-1:0] : '0;
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			irq_st_q <= '0;
		else
			irq_st_q <= (irq_st_q & ~irq_clr) | (fire ? pick : '0);
	end

	// Detector enables persist through system resets
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			mcd_en_q <= 1'b0;
			cmp_en_q <= 1'b0;
		end else if (do_wr && aw_addr_q == ADDR_RST_SRC && w_strb_q[0]) begin
			mcd_en_q <= w_data_q[BIT_MCD];
			cmp_en_q <= w_data_q[BIT_CMP];
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N)
			sw_req_q <= 1'b0;
		else
			sw_req_q <= do_wr && aw_addr_q == ADDR_RST_SRC && w_strb_q[0]
				&& w_data_q[BIT_SW];
	end

	// Watchdog returns to enabled on every reset
	always_ff @(posedge MCLK) begin
		if (!RST_N || rst_active)
			wdt_en_q <= 1'b1;
		else if (do_wr && aw_addr_q == ADDR_WDT_CTRL && w_strb_q[0])
			wdt_en_q <= w_data_q[BIT_WDT_EN];
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			wdt_lim_q <= WDT_LIM_RST;
			irq_en_q  <= '0;
		end else if (do_wr) begin
			if (aw_addr_q == ADDR_WDT_LIM)
				wdt_lim_q <= lim_word[15:0];
			if (aw_addr_q == ADDR_IRQ_EN && w_strb_q[0])
				irq_en_q <= w_data_q[NUM_EV-1:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N)
			kick_q <= 1'b0;
		else
			kick_q <= do_wr && aw_addr_q == ADDR_WDT_KICK;
	end

	// Write channel; address and data taken in either order
	assign S_AXI_AWREADY = !aw_have_q;
	assign S_AXI_WREADY  = !w_have_q;
	assign do_wr         = aw_have_q && w_have_q && !S_AXI_BVALID;

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= {S_AXI_AWADDR[7:2], 2'b00};
		end else if (do_wr) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_have_q <= 1'b1;
			w_data_q <= S_AXI_WDATA;
			w_strb_q <= S_AXI_WSTRB;
		end else if (do_wr) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= RESP_OKAY;
		end else if (do_wr) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= mapped(aw_addr_q) ? RESP_OKAY : RESP_DECERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// Read channel; bit 5 shows comparator or watchdog cause
	always_comb begin
		rd_word = 32'h0000_0000;
		case ({S_AXI_ARADDR[7:2], 2'b00})
			ADDR_RST_SRC: begin
				rd_word[BIT_MCD] = cause_q[EV_MCD];
				rd_word[BIT_SW]  = cause_q[EV_SW];
				rd_word[BIT_CMP] = cause_q[EV_CMP] | cause_q[EV_WDT];
				rd_word[BIT_MEM] = cause_q[EV_MEM];
			end
			ADDR_CAUSE:    rd_word[NUM_EV-1:0] = cause_q;
			ADDR_WDT_CTRL: rd_word[BIT_WDT_EN] = wdt_en_q;
			ADDR_WDT_LIM:  rd_word[15:0] = wdt_lim_q;
			ADDR_IRQ_STAT: rd_word[NUM_EV-1:0] = irq_st_q;
			ADDR_IRQ_EN:   rd_word[NUM_EV-1:0] = irq_en_q;
			default:       rd_word = 32'h0000_0000;
		endcase
	end

	assign S_AXI_ARREADY = !S_AXI_RVALID;

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0000_0000;
			S_AXI_RRESP  <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_word;
			S_AXI_RRESP  <= mapped({S_AXI_ARADDR[7:2], 2'b00}) ? RESP_OKAY : RESP_DECERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// Checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	chk_mcd_trip_reset: assert property (
		mcd_trip && state_q == ST_RUN && !mem_err && !wd.timeout && !cmp_trip
		|=> !SYS_RST_N && cause_q[EV_MCD])
		else $error("missing clock did not reset");
	chk_mcd_flag_only: assert property (
		$rose(rst_active) && !$past(mcd_trip) |-> !cause_q[EV_MCD])
		else $error("missing clock flag set by other source");
	chk_mcd_off_quiet: assert property (
		!mcd_en_q |-> mcd_cnt_q == 12'h000 && !mcd_trip)
		else $error("disabled detector counting");
	chk_cmp_gate_off: assert property (
		!cmp_en_q |-> !cmp_trip)
		else $error("comparator reset while not armed");
	chk_cmp_hold_rst: assert property (
		rst_active && cmp_trip |=> rst_active)
		else $error("reset released with comparator low");
	chk_wdt_on_reset: assert property (
		$fell(rst_active) |-> wdt_en_q)
		else $error("watchdog not enabled after reset");
	chk_mem_err_reset: assert property (
		state_q == ST_RUN && mem_err |=> rst_active && cause_q == NUM_EV'(1 << EV_MEM))
		else $error("memory error not taken");
	chk_sw_reset_flow: assert property (
		state_q == ST_RUN && sw_req_q && !mem_err && !wd.timeout && !cmp_trip
		&& !mcd_trip |=> rst_active ##0 cause_q[EV_SW])
		else $error("software reset not taken");
	chk_hold_min_len: assert property (
		$rose(rst_active) |-> rst_active [*4])
		else $error("reset pulse too short");
	chk_one_cause_bit: assert property (
		rst_active |-> $onehot(cause_q))
		else $error("cause flags not one-hot");
	chk_set_beats_clr: assert property (
		fire && (irq_clr & pick) != '0 |=> (irq_st_q & $past(pick)) != '0)
		else $error("event lost to clear");

	cov_mcd_reset: cover property ($rose(rst_active) && cause_q[EV_MCD]);
	cov_wdt_reset: cover property ($rose(rst_active) && cause_q[EV_WDT]);
	cov_cmp_hold:  cover property (rst_active && cmp_trip && hold_q == HOLD_END);
	cov_sw_reset:  cover property ($fell(rst_active) && cause_q[EV_SW]);
endmodule // mrs_reset_top
`default_nettype wire

/* test/mrs_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mrs_cpu_model (
	input  wire logic        clk,
	output var  logic        pwe,
	output var  logic        dwr,
	output var  logic [15:0] daddr,
	output var  logic        trd,
	output var  logic [15:0] taddr,
	output var  logic        bfetch,
	output var  logic [15:0] faddr,
	output var  logic        secb
);
	initial begin
		{pwe, dwr, trd, bfetch, secb} = 5'h00;
		{daddr, taddr, faddr} = 48'h0;
	end
	// One-cycle access pulse; idle address lines show the inverse, never a stale copy
	task automatic access(input int k, input logic [15:0] a, input logic we);
		@(posedge clk);
		pwe <= we;
		daddr <= a;
		taddr <= a;
		faddr <= a;
		dwr <= (k == 0);
		trd <= (k == 1);
		bfetch <= (k == 2);
		secb <= (k == 3);
		@(posedge clk);
		{pwe, dwr, trd, bfetch, secb} <= 5'h00;
		daddr <= ~a;
		taddr <= ~a;
		faddr <= ~a;
	endtask
endmodule // mrs_cpu_model
`default_nettype wire

/* test/mrs_reset_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module mrs_reset_top_tb_top
	import mrs_pkg::*;
;
	localparam int HOLD = 4;
	localparam int TMO  = 20000;
	logic        mclk = 1'h0, rst_n = 1'h0, sense_run = 1'h1, clk_sense = 1'h0, cmp_above = 1'h1;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awready, wready, bvalid, arready, rvalid, pwe, dwr, trd, bfetch, secb;
	logic        sys_rst_n, irq;
	logic [1:0]  bresp, rresp;
	logic [15:0] daddr, taddr, faddr;
	logic [31:0] rdata;
	int          errors = 0, cmp_count = 0, cyc = 0, low_cyc = 0, lat, len, base;

	mrs_reset_top #(.HOLD_CYC(HOLD)) u_mrs_reset_top (
		.MCLK(mclk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.CLK_SENSE(clk_sense), .CMP_ABOVE(cmp_above), .PROG_WRITE_EN(pwe),
		.DMOVE_WR(dwr), .DMOVE_ADDR(daddr), .TABLE_RD(trd), .TABLE_ADDR(taddr),
		.BRANCH_FETCH(bfetch), .FETCH_ADDR(faddr), .SECURITY_BLOCK(secb),
		.SYS_RST_N(sys_rst_n), .IRQ(irq)
	);

	mrs_cpu_model u_mrs_cpu_model (
		.clk(mclk), .pwe(pwe), .dwr(dwr), .daddr(daddr), .trd(trd), .taddr(taddr),
		.bfetch(bfetch), .faddr(faddr), .secb(secb)
	);

	always #25 mclk = ~mclk;

	// Monitored clock toggles every cycle unless a scenario stops it
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (sense_run) begin
			clk_sense <= ~clk_sense;
		end
		if (rst_n && sys_rst_n !== 1'h1) begin
			low_cyc <= low_cyc + 1;
		end
		if (cyc == TMO) begin
			errors++;
			$display("ERROR timeout expected done seen hang");
			results();
		end
	end

	task automatic results();
		$display("Checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic okc(input string n, input logic c);
		chk(n, 32'h1, 32'(c));
	endtask

	// Address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw && w)) begin
			@(posedge mclk);
			if (awvalid && awready === 1'h1) begin
				aw = 1'h1;
				awvalid <= 1'h0;
			end
			if (wvalid && wready === 1'h1) begin
				w = 1'h1;
				wvalid <= 1'h0;
			end
		end
		while (bvalid !== 1'h1) @(posedge mclk);
		bready <= 1'h0;
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string n);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge mclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge mclk); while (rvalid !== 1'h1);
		rready <= 1'h0;
		chk(n, e, rdata);
		chk("rresp", 32'(er), 32'(rresp));
	endtask

	task automatic wait_rst();
		lat = 0;
		len = 0;
		while (sys_rst_n === 1'h1) begin
			@(posedge mclk);
			lat++;
		end
		while (sys_rst_n !== 1'h1) begin
			@(posedge mclk);
			len++;
		end
	endtask

	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'h1;
		rd(ADDR_RST_SRC, 32'h0, RESP_OKAY, "rst_src");
		rd(ADDR_CAUSE, 32'h0, RESP_OKAY, "cause");
		rd(ADDR_WDT_CTRL, 32'h1, RESP_OKAY, "wdt_ctrl");
		rd(ADDR_WDT_LIM, 32'h0000FFFF, RESP_OKAY, "wdt_lim");
		rd(8'h40, 32'h0, RESP_DECERR, "unmapped");
		wr(8'h40, 32'hFFFFFFFF, RESP_DECERR);
		// Software reset, then its interrupt masked, enabled, cleared
		wr(ADDR_RST_SRC, 32'h10, RESP_OKAY);
		wait_rst();
		okc("sw_lat", lat <= 3);
		okc("sw_hold", len >= HOLD && len <= HOLD + 1);
		rd(ADDR_RST_SRC, 32'h10, RESP_OKAY, "sw_src");
		rd(ADDR_CAUSE, 32'h10, RESP_OKAY, "sw_cause");
		rd(ADDR_IRQ_STAT, 32'h10, RESP_OKAY, "irq_stat");
		chk("irq_masked", 32'h0, 32'(irq));
		wr(ADDR_IRQ_EN, 32'h10, RESP_OKAY);
		@(negedge mclk);
		chk("irq_on", 32'h1, 32'(irq));
		wr(ADDR_IRQ_CLR, 32'h10, RESP_OKAY);
		@(negedge mclk);
		chk("irq_off", 32'h0, 32'(irq));
		rd(ADDR_IRQ_STAT, 32'h0, RESP_OKAY, "irq_clr");
		// Each memory fault kind: a legal access first (table and fetch at the limit, write to FFFF with pwe low, none for security), then one past the limit
		for (int k = 0; k < 4; k++) begin
			base = low_cyc;
			u_mrs_cpu_model.access((k == 3) ? 4 : k, (k == 0) ? 16'hFFFF : LIMIT_8K, 1'h0);
			repeat (6) @(posedge mclk);
			chk("mem_legal", 32'(base), 32'(low_cyc));
			u_mrs_cpu_model.access(k, LIMIT_8K + 16'h1, 1'h1);
			wait_rst();
			okc("mem_lat", lat <= 4);
			rd(ADDR_CAUSE, 32'h01, RESP_OKAY, "mem_cause");
			rd(ADDR_RST_SRC, 32'h40, RESP_OKAY, "mem_src");
		end
		// Comparator ignored until armed; armed only once settled high
		base = low_cyc;
		@(posedge mclk);
		cmp_above <= 1'h0;
		repeat (10) @(posedge mclk);
		chk("cmp_unarmed", 32'(base), 32'(low_cyc));
		cmp_above <= 1'h1;
		repeat (5) @(posedge mclk);
		wr(ADDR_RST_SRC, 32'h20, RESP_OKAY);
		@(posedge mclk);
		cmp_above <= 1'h0;
		repeat (3) @(posedge mclk);
		chk("cmp_trip", 32'h0, 32'(sys_rst_n));
		base = low_cyc;
		repeat (20) @(posedge mclk);
		chk("cmp_held", 32'(base + 20), 32'(low_cyc));
		cmp_above <= 1'h1;
		wait_rst();
		okc("cmp_release", len <= 3);
		rd(ADDR_CAUSE, 32'h04, RESP_OKAY, "cmp_cause");
		rd(ADDR_RST_SRC, 32'h20, RESP_OKAY, "cmp_src");
		// Missing clock: enabling also disarms the comparator
		wr(ADDR_RST_SRC, 32'h04, RESP_OKAY);
		base = low_cyc;
		repeat (2100) @(posedge mclk);
		chk("mcd_running", 32'(base), 32'(low_cyc));
		sense_run <= 1'h0;
		wait_rst();
		sense_run <= 1'h1;
		okc("mcd_lat", lat >= MCD_CYC - 2 && lat <= MCD_CYC + 3);
		rd(ADDR_CAUSE, 32'h08, RESP_OKAY, "mcd_cause");
		rd(ADDR_RST_SRC, 32'h04, RESP_OKAY, "mcd_src");
		wr(ADDR_RST_SRC, 32'h0, RESP_OKAY);
		sense_run <= 1'h0;
		base = low_cyc;
		repeat (2100) @(posedge mclk);
		chk("mcd_off", 32'(base), 32'(low_cyc));
		sense_run <= 1'h1;
		// Watchdog: kicks keep it quiet, silence trips it; ends the run
		wr(ADDR_WDT_LIM, 32'h2, RESP_OKAY);
		base = low_cyc;
		repeat (3) begin
			repeat (10) @(posedge mclk);
			wr(ADDR_WDT_KICK, 32'h0, RESP_OKAY);
		end
		chk("wdt_kicked", 32'(base), 32'(low_cyc));
		wait_rst();
		okc("wdt_lat", lat >= 2 * WDT_DIV && lat <= 3 * WDT_DIV + 4);
		rd(ADDR_WDT_CTRL, 32'h1, RESP_OKAY, "wdt_ctrl");
		rd(ADDR_CAUSE, 32'h02, RESP_OKAY, "wdt_cause");
		rd(ADDR_RST_SRC, 32'h20, RESP_OKAY, "wdt_src");
		results();
	end
endmodule // mrs_reset_top_tb_top
`default_nettype wire
